// File: pkg/asm_pkg.sv
//==============================================================
package asm_pkg;
  localparam int LA_W      = 24;
  localparam int PA_W      = 21;
  localparam int SEG_W     = 7;
  localparam int PDISP_W   = 8;
  localparam int OFS_W     = 9;
  localparam int PAGE_W    = 12;
  localparam int CTX_W     = 2;
  localparam int REG_W     = 12;
  localparam int MAP_AW    = CTX_W + SEG_W;
  localparam int SEG_LSB   = 17;
  localparam int PDISP_LSB = 9;
  localparam int TYPE_LSB  = 8;
  localparam int TYPE_W    = 4;
  localparam int WIN_W     = 16;
  localparam int REGSEL_BIT = 3;
  // segment type codes held in the top nibble of the limit word
  localparam logic [3:0] TYP_RO_STACK = 4'h4;
  localparam logic [3:0] TYP_RO       = 4'h5;
  localparam logic [3:0] TYP_STACK    = 4'h6;
  localparam logic [3:0] TYP_RAM      = 4'h7;
  localparam logic [3:0] TYP_IO       = 4'h9;
  localparam logic [3:0] TYP_SIO      = 4'hF;
  // window selectors within a 64K I/O or special I/O window
  localparam logic [1:0] SIO_ROM_WIN  = 2'h0;
  localparam logic [1:0] SIO_REG_WIN  = 2'h2;
  localparam logic [1:0] SLOT_LAST    = 2'h2;
  localparam logic [3:0] WIN_FLOPPY   = 4'hC;
  localparam logic [3:0] WIN_IOB_DEV  = 4'hD;
  localparam logic [3:0] WIN_CPUB_DEV = 4'hE;
  localparam logic [4:0] IO_HI_ZERO   = 5'h00;
endpackage

// File: pkg/asm_map_if.sv
`timescale 1ns/1ps
interface asm_map_if;
  import asm_pkg::*;
  logic [MAP_AW-1:0]  addr;
  logic               we_sor;
  logic               we_slr;
  logic [REG_W-1:0]   wdata;
  logic [2*REG_W-1:0] rdata;
  modport ctrl (output addr, output we_sor, output we_slr, output wdata, input rdata);
  modport mem  (input addr, input we_sor, input we_slr, input wdata, output rdata);
endinterface

// File: core/asm_map_ram.sv
`timescale 1ns/1ps
module asm_map_ram
  import asm_pkg::*;
(
  input wire logic clk,
  input wire logic ce,
  asm_map_if.mem   bus
);
  // {limit word, origin word} per context and segment
  logic [REG_W-1:0] sor_mem [2**MAP_AW];
  logic [REG_W-1:0] slr_mem [2**MAP_AW];
  logic [2*REG_W-1:0] rdata_q;

  always_ff @(posedge clk) begin
    if (ce) begin
      if (bus.we_sor) begin
        sor_mem[bus.addr] <= bus.wdata;
      end
      if (bus.we_slr) begin
        slr_mem[bus.addr] <= bus.wdata;
      end
      rdata_q <= {slr_mem[bus.addr], sor_mem[bus.addr]};
    end
  end

  assign bus.rdata = rdata_q;
endmodule // asm_map_ram

// File: core/asm_mapper.sv
`timescale 1ns/1ps
module asm_mapper
  import asm_pkg::*;
(
  input  wire logic              SYS_CLK,
  input  wire logic              SRST,
  input  wire logic              CE,
  input  wire logic              CYC_VALID,
  input  wire logic [LA_W-1:0]   LOG_ADDR,
  input  wire logic              CYC_WRITE,
  input  wire logic [REG_W-1:0]  CYC_WDATA,
  input  wire logic [CTX_W-1:0]  CONTEXT,
  input  wire logic              SETUP_MODE,
  output logic                   RESULT_VALID,
  output logic [PA_W-1:0]        PHYS_ADDR,
  output logic                   SEL_RAM,
  output logic                   SEL_IO,
  output logic                   SEL_SIO,
  output logic [2:0]             SEL_SLOT,
  output logic                   SLOT_HIGH,
  output logic                   SEL_FLOPPY_DISK_MEM,
  output logic                   SEL_IOB_DEV,
  output logic                   SEL_CPUB_DEV,
  output logic                   SEL_BOOT_ROM,
  output logic                   SEL_MAP_REG,
  output logic                   FLAG_STACK,
  output logic                   FLAG_RO,
  output logic                   FLAG_IO,
  output logic                   ERR_LIMIT,
  output logic                   ERR_WRITE_RO,
  output logic                   ERR_INVALID,
  output logic [REG_W-1:0]       MAP_RDATA,
  output logic                   MEM_STROBE,
  output logic                   MEM_WE,
  output logic [PA_W-1:0]        MEM_ADDR
);
  //==============================================================
  // helpers
  function automatic logic page_ok(input logic [PDISP_W-1:0] disp,
                                   input logic [PDISP_W-1:0] lim,
                                   input logic               stack);
    // stack segments grow down, so the limit is a floor there
    page_ok = stack ? (disp >= lim) : (disp <= lim);
  endfunction

  function automatic logic in_io_win(input logic [PA_W-1:0] pa, input logic [3:0] win);
    in_io_win = (pa[PA_W-1:WIN_W] == IO_HI_ZERO) && (pa[WIN_W-1:WIN_W-4] == win);
  endfunction

  //==============================================================
  // stage 1: map lookup in flight
  asm_map_if mbus ();

  asm_map_ram u_ram (
    .clk (SYS_CLK),
    .ce  (CE),
    .bus (mbus)
  );

  logic              s1_valid_q, s1_valid_d;
  logic [LA_W-1:0]   s1_addr_q, s1_addr_d;
  logic              s1_write_q, s1_write_d;
  logic              s1_setup_q, s1_setup_d;
  logic              req_reg;

  always_comb begin
    // registers are only reachable untranslated, while set up
    req_reg = SETUP_MODE && (LOG_ADDR[WIN_W-1:WIN_W-2] == SIO_REG_WIN);
    mbus.addr   = {CONTEXT, LOG_ADDR[SEG_LSB +: SEG_W]};
    mbus.wdata  = CYC_WDATA;
    mbus.we_sor = CYC_VALID && CYC_WRITE && req_reg && !LOG_ADDR[REGSEL_BIT];
    mbus.we_slr = CYC_VALID && CYC_WRITE && req_reg && LOG_ADDR[REGSEL_BIT];
    s1_valid_d  = CYC_VALID;
    s1_addr_d   = LOG_ADDR;
    s1_write_d  = CYC_WRITE;
    s1_setup_d  = SETUP_MODE;
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      s1_valid_q <= 1'b0;
      s1_addr_q  <= '0;
      s1_write_q <= 1'b0;
      s1_setup_q <= 1'b0;
    end else if (CE) begin
      s1_valid_q <= s1_valid_d;
      s1_addr_q  <= s1_addr_d;
      s1_write_q <= s1_write_d;
      s1_setup_q <= s1_setup_d;
    end
  end

  //==============================================================
  // stage 2: translate, check and decode
  logic [REG_W-1:0]   sor, slr;
  logic [3:0]         typ;
  logic [PDISP_W-1:0] disp;
  logic [PAGE_W-1:0]  page;
  logic [PA_W-1:0]    pa;
  logic               is_ram, is_io, is_sio, is_stack, is_ro, bad_typ, lim_ok, ro_hit;
  logic [2:0]         slot_d;

  logic              valid_d, sel_ram_d, sel_io_d, sel_sio_d, slot_high_d;
  logic              floppy_d, iob_d, cpub_d, rom_d, mreg_d;
  logic              fstack_d, fro_d, fio_d, elim_d, ero_d, einv_d, mstb_d, mwe_d;
  logic [PA_W-1:0]   pa_d;
  logic [REG_W-1:0]  mrd_d;

  logic              valid_q, sel_ram_q, sel_io_q, sel_sio_q, slot_high_q;
  logic              floppy_q, iob_q, cpub_q, rom_q, mreg_q;
  logic              fstack_q, fro_q, fio_q, elim_q, ero_q, einv_q, mstb_q, mwe_q;
  logic [PA_W-1:0]   pa_q, maddr_q;
  logic [REG_W-1:0]  mrd_q;
  logic [2:0]        slot_q;

  always_comb begin
    sor  = mbus.rdata[REG_W-1:0];
    slr  = mbus.rdata[2*REG_W-1:REG_W];
    typ  = slr[TYPE_LSB +: TYPE_W];
    disp = s1_addr_q[PDISP_LSB +: PDISP_W];
    page = sor + {{(PAGE_W-PDISP_W){1'b0}}, disp};
    is_stack = !s1_setup_q && (typ == TYP_STACK || typ == TYP_RO_STACK);
    is_ro    = !s1_setup_q && (typ == TYP_RO || typ == TYP_RO_STACK);
    is_ram   = !s1_setup_q && (typ inside {TYP_RO_STACK, TYP_RO, TYP_STACK, TYP_RAM});
    is_io    = !s1_setup_q && (typ == TYP_IO);
    is_sio   = s1_setup_q || (typ == TYP_SIO);
    bad_typ  = !(is_ram || is_io || is_sio);
    lim_ok   = s1_setup_q || page_ok(disp, slr[PDISP_W-1:0], is_stack);
    ro_hit   = is_ro && s1_write_q;
    // untranslated while set up; byte offset always passes straight through
    pa = s1_setup_q ? s1_addr_q[PA_W-1:0]
                    : {page, s1_addr_q[OFS_W-1:0]};
    slot_d = '0;
    if (pa[PA_W-1:WIN_W] == IO_HI_ZERO && pa[WIN_W-1:WIN_W-2] <= SLOT_LAST) begin
      slot_d[pa[WIN_W-1:WIN_W-2]] = 1'b1;
    end

    valid_d     = s1_valid_q;
    pa_d        = pa;
    // one space at most per cycle, no overlap between them
    sel_ram_d   = s1_valid_q && is_ram && lim_ok && !ro_hit;
    sel_io_d    = s1_valid_q && is_io && lim_ok;
    sel_sio_d   = s1_valid_q && is_sio && lim_ok;
    slot_high_d = pa[WIN_W-3];
    slot_d      = sel_io_d ? slot_d : 3'h0;
    floppy_d    = sel_io_d && in_io_win(pa, WIN_FLOPPY);
    iob_d       = sel_io_d && in_io_win(pa, WIN_IOB_DEV);
    cpub_d      = sel_io_d && in_io_win(pa, WIN_CPUB_DEV);
    // the two top hex digits are ignored in special space
    rom_d       = sel_sio_d && (pa[WIN_W-1:WIN_W-2] == SIO_ROM_WIN);
    mreg_d      = sel_sio_d && s1_setup_q
                  && (pa[WIN_W-1:WIN_W-2] == SIO_REG_WIN);
    mrd_d       = s1_addr_q[REGSEL_BIT] ? slr : sor;
    fstack_d    = s1_valid_q && is_stack;
    fro_d       = s1_valid_q && is_ro;
    fio_d       = s1_valid_q && is_io;
    elim_d      = s1_valid_q && !bad_typ && !lim_ok;
    ero_d       = s1_valid_q && ro_hit;
    einv_d      = s1_valid_q && bad_typ;
    mstb_d      = sel_ram_d;
    mwe_d       = sel_ram_d && s1_write_q;
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      valid_q <= 1'b0; pa_q <= '0; maddr_q <= '0; mrd_q <= '0; slot_q <= '0;
      sel_ram_q <= 1'b0; sel_io_q <= 1'b0; sel_sio_q <= 1'b0; slot_high_q <= 1'b0;
      floppy_q <= 1'b0; iob_q <= 1'b0; cpub_q <= 1'b0; rom_q <= 1'b0; mreg_q <= 1'b0;
      fstack_q <= 1'b0; fro_q <= 1'b0; fio_q <= 1'b0; elim_q <= 1'b0;
      ero_q <= 1'b0; einv_q <= 1'b0; mstb_q <= 1'b0; mwe_q <= 1'b0;
    end else if (CE) begin
      valid_q <= valid_d; pa_q <= pa_d; maddr_q <= pa_d; mrd_q <= mrd_d; slot_q <= slot_d;
      sel_ram_q <= sel_ram_d; sel_io_q <= sel_io_d; sel_sio_q <= sel_sio_d;
      slot_high_q <= slot_high_d;
      floppy_q <= floppy_d; iob_q <= iob_d; cpub_q <= cpub_d; rom_q <= rom_d;
      mreg_q <= mreg_d;
      fstack_q <= fstack_d; fro_q <= fro_d; fio_q <= fio_d; elim_q <= elim_d;
      ero_q <= ero_d; einv_q <= einv_d; mstb_q <= mstb_d; mwe_q <= mwe_d;
    end
  end

  assign RESULT_VALID        = valid_q;
  assign PHYS_ADDR           = pa_q;
  assign SEL_RAM             = sel_ram_q;
  assign SEL_IO              = sel_io_q;
  assign SEL_SIO             = sel_sio_q;
  assign SEL_SLOT            = slot_q;
  assign SLOT_HIGH           = slot_high_q;
  assign SEL_FLOPPY_DISK_MEM = floppy_q;
  assign SEL_IOB_DEV         = iob_q;
  assign SEL_CPUB_DEV        = cpub_q;
  assign SEL_BOOT_ROM        = rom_q;
  assign SEL_MAP_REG         = mreg_q;
  assign FLAG_STACK          = fstack_q;
  assign FLAG_RO             = fro_q;
  assign FLAG_IO             = fio_q;
  assign ERR_LIMIT           = elim_q;
  assign ERR_WRITE_RO        = ero_q;
  assign ERR_INVALID         = einv_q;
  assign MAP_RDATA           = mrd_q;
  assign MEM_STROBE          = mstb_q;
  assign MEM_WE              = mwe_q;
  assign MEM_ADDR            = maddr_q;
endmodule // asm_mapper

// File: bench/asm_mapper_asserts.sv
`timescale 1ns/1ps
module asm_mapper_asserts
  import asm_pkg::*;
(
  input wire logic            SYS_CLK,
  input wire logic            SRST,
  input wire logic            CE,
  input wire logic            CYC_VALID,
  input wire logic            SETUP_MODE,
  input wire logic [LA_W-1:0] LOG_ADDR,
  input wire logic            RESULT_VALID,
  input wire logic [PA_W-1:0] PHYS_ADDR,
  input wire logic            SEL_RAM,
  input wire logic            SEL_IO,
  input wire logic            SEL_SIO,
  input wire logic [2:0]      SEL_SLOT,
  input wire logic            SEL_FLOPPY_DISK_MEM,
  input wire logic            SEL_BOOT_ROM,
  input wire logic            ERR_LIMIT,
  input wire logic            ERR_WRITE_RO,
  input wire logic            MEM_STROBE,
  input wire logic [PA_W-1:0] MEM_ADDR
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SRST);
  // =============
  // request pipeline
  sequence s_req;
    CE && CYC_VALID;
  endsequence
  sequence s_run;
    CE ##1 CE;
  endsequence
  // a frozen cycle stretches the pipe, so only unfrozen results are traced back
  sequence s_fresh;
    RESULT_VALID && $past(CE) && $past(CE, 2);
  endsequence
  property p_lat;
    s_req ##1 s_run |-> RESULT_VALID;
  endproperty
  a_lat: assert property (p_lat) else $error("result missing");
  property p_cause;
    s_fresh |-> $past(CYC_VALID, 2);
  endproperty
  a_cause: assert property (p_cause) else $error("result without request");
  property p_ofs;
    s_fresh |-> PHYS_ADDR[8:0] == $past(LOG_ADDR[8:0], 2);
  endproperty
  a_ofs: assert property (p_ofs) else $error("offset changed");
  property p_setup;
    s_req ##0 SETUP_MODE ##1 s_run |->
      SEL_SIO && {3'h0, PHYS_ADDR} == ($past(LOG_ADDR, 2) & 24'h1FFFFF);
  endproperty
  a_setup: assert property (p_setup) else $error("setup access wrong");
  // =============
  // decode
  property p_onesp;
    $onehot0({SEL_RAM, SEL_IO, SEL_SIO});
  endproperty
  a_onesp: assert property (p_onesp) else $error("spaces overlap");
  property p_slot;
    |SEL_SLOT |-> SEL_IO && $onehot(SEL_SLOT) && PHYS_ADDR[20:16] == 5'h00;
  endproperty
  a_slot: assert property (p_slot) else $error("slot select wrong");
  property p_fdw;
    SEL_FLOPPY_DISK_MEM |-> SEL_IO && PHYS_ADDR[20:12] == 9'h00C;
  endproperty
  a_fdw: assert property (p_fdw) else $error("disk window wrong");
  property p_boot;
    SEL_BOOT_ROM |-> SEL_SIO && PHYS_ADDR[15:14] == 2'h0;
  endproperty
  a_boot: assert property (p_boot) else $error("boot window wrong");
  property p_chk;
    SEL_RAM |-> !ERR_LIMIT && !ERR_WRITE_RO;
  endproperty
  a_chk: assert property (p_chk) else $error("ram selected on fault");
  property p_mem;
    MEM_STROBE |-> SEL_RAM && MEM_ADDR == PHYS_ADDR;
  endproperty
  a_mem: assert property (p_mem) else $error("memory strobe wrong");
endmodule // asm_mapper_asserts
bind asm_mapper asm_mapper_asserts u_chk (.*);

// File: bench/asm_cpu_model.sv
`timescale 1ns/1ps
module asm_cpu_model
  import asm_pkg::*;
(
  input  wire logic             SYS_CLK,
  output logic                  CYC_VALID,
  output logic [LA_W-1:0]       LOG_ADDR,
  output logic                  CYC_WRITE,
  output logic [REG_W-1:0]      CYC_WDATA,
  output logic [CTX_W-1:0]      CONTEXT,
  output logic                  SETUP_MODE
);
  initial begin
    CYC_VALID = 1'b0;
    LOG_ADDR = '0;
    CYC_WRITE = 1'b0;
    CYC_WDATA = '0;
    CONTEXT = '0;
    SETUP_MODE = 1'b0;
  end
  // released address, write and data lines carry inverted junk; context and setup mode keep the last value
  task automatic issue(input logic [LA_W-1:0] a, input logic w, input logic [REG_W-1:0] d,
                       input logic [CTX_W-1:0] c, input logic s);
    @(negedge SYS_CLK);
    CYC_VALID = 1'b1;
    LOG_ADDR = a;
    CYC_WRITE = w;
    CYC_WDATA = d;
    CONTEXT = c;
    SETUP_MODE = s;
    @(negedge SYS_CLK);
    CYC_VALID = 1'b0;
    LOG_ADDR = ~a;
    CYC_WRITE = ~w;
    CYC_WDATA = ~d;
  endtask
endmodule // asm_cpu_model

// File: bench/asm_mapper_bench.sv
`timescale 1ns/1ps
module asm_mapper_bench;
  import asm_pkg::*;
  logic SYS_CLK = 1'b0, SRST = 1'b1, CE = 1'b1;
  logic CYC_VALID, CYC_WRITE, SETUP_MODE, RESULT_VALID, SEL_RAM, SEL_IO, SEL_SIO;
  logic SLOT_HIGH, SEL_FLOPPY_DISK_MEM, SEL_IOB_DEV, SEL_CPUB_DEV, SEL_BOOT_ROM, SEL_MAP_REG;
  logic FLAG_STACK, FLAG_RO, FLAG_IO, ERR_LIMIT, ERR_WRITE_RO, ERR_INVALID, MEM_STROBE, MEM_WE;
  logic [LA_W-1:0] LOG_ADDR;
  logic [REG_W-1:0] CYC_WDATA, MAP_RDATA;
  logic [CTX_W-1:0] CONTEXT;
  logic [PA_W-1:0] PHYS_ADDR, MEM_ADDR;
  logic [2:0] SEL_SLOT;
  int err_total = 0;
  int checks = 0;
  asm_mapper DUT (.*);
  asm_cpu_model u_cpu (.*);
  always #20 SYS_CLK = ~SYS_CLK;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %0h exp %0h", $time, g, e);
    end
  endtask
  // result stands one cycle only, from the first edge after the taken one
  task automatic acc(input logic [23:0] a, input logic [1:0] c, input logic w = 1'b0,
                     input logic s = 1'b0, input logic [11:0] d = 12'h000);
    u_cpu.issue(a, w, d, c, s);
    @(negedge SYS_CLK);
  endtask
  task automatic wmap(input logic [1:0] c, input logic [6:0] g, input logic [11:0] so,
                      input logic [11:0] sl);
    acc({g, 17'h08000}, c, 1'b1, 1'b1, so);
    acc({g, 17'h08008}, c, 1'b1, 1'b1, sl);
  endtask
  task automatic t_ram;
    wmap(2'h1, 7'h01, 12'h010, {TYP_RAM, 8'h03});
    acc({7'h01, 17'h08008}, 2'h1, 1'b0, 1'b1);
    chk({SEL_MAP_REG, MAP_RDATA}, {1'b1, TYP_RAM, 8'h03});
    acc({7'h01, 8'h03, 9'h1AB}, 2'h1);
    chk({RESULT_VALID, SEL_RAM, MEM_STROBE, MEM_ADDR}, {3'h7, 12'h013, 9'h1AB});
    acc({7'h01, 8'h04, 9'h000}, 2'h1);
    chk({SEL_RAM, MEM_STROBE, ERR_LIMIT}, 3'b001);
    acc({7'h01, 8'h02, 9'h010}, 2'h1, 1'b1);
    chk({SEL_RAM, MEM_STROBE, MEM_WE, MEM_ADDR}, {3'h7, 12'h012, 9'h010});
    wmap(2'h2, 7'h01, 12'h100, {TYP_RAM, 8'hFF});
    acc({7'h01, 8'h03, 9'h1AB}, 2'h2);
    chk(PHYS_ADDR, {12'h103, 9'h1AB});
    $display("ram test done");
  endtask
  task automatic t_io;
    logic [15:0] win [8] = '{16'h0000, 16'h2000, 16'h4000, 16'h8000,
                             16'hA000, 16'hC000, 16'hD000, 16'hE000};
    logic [15:0] p;
    logic [2:0] sl;
    wmap(2'h0, 7'h02, 12'h000, {TYP_IO, 8'hFF});
    for (int i = 0; i < 8; i++) begin
      p = win[i];
      sl = (p[15:14] == 2'h3) ? 3'h0 : 3'h1 << p[15:14];
      acc({8'h04, p}, 2'h0);
      chk({SEL_IO, SEL_RAM, SEL_SLOT, SLOT_HIGH, FLAG_IO}, {2'b10, sl, p[13], 1'b1});
      chk({SEL_FLOPPY_DISK_MEM, SEL_IOB_DEV, SEL_CPUB_DEV},
          {p[15:12] == 4'hC, p[15:12] == 4'hD, p[15:12] == 4'hE});
    end
    $display("io test done");
  endtask
  task automatic t_sio;
    acc(24'hAB2345, 2'h0, 1'b0, 1'b1);
    chk({SEL_SIO, SEL_BOOT_ROM, SEL_RAM, PHYS_ADDR}, {3'b110, 21'h0B2345});
    wmap(2'h3, 7'h01, 12'h020, {TYP_RO_STACK, 8'h00});
    acc({7'h01, 8'h05, 9'h000}, 2'h3, 1'b1);
    chk({SEL_RAM, MEM_STROBE, ERR_WRITE_RO, FLAG_RO, FLAG_STACK, ERR_LIMIT}, 6'b001110);
    acc({7'h01, 8'h05, 9'h000}, 2'h3);
    chk({SEL_RAM, FLAG_STACK, ERR_LIMIT, PHYS_ADDR}, {3'b110, 12'h025, 9'h000});
    wmap(2'h0, 7'h05, 12'h000, {TYP_SIO, 8'hFF});
    acc({7'h05, 8'h00, 9'h004}, 2'h0);
    chk({SEL_SIO, SEL_BOOT_ROM, SEL_MAP_REG, SEL_RAM}, 4'b1100);
    $display("special test done");
  endtask
  // clock enable low must hold a request in flight
  task automatic t_hold;
    wmap(2'h1, 7'h03, 12'h000, 12'h000);
    acc({7'h03, 17'h00000}, 2'h1);
    chk({ERR_INVALID, SEL_RAM, SEL_IO, SEL_SIO}, 4'b1000);
    u_cpu.issue({7'h01, 8'h01, 9'h055}, 1'b0, 12'h000, 2'h2, 1'b0);
    CE = 1'b0;
    @(negedge SYS_CLK);
    chk(RESULT_VALID, 1'b0);
    CE = 1'b1;
    @(negedge SYS_CLK);
    chk({RESULT_VALID, PHYS_ADDR}, {1'b1, 12'h101, 9'h055});
    $display("hold test done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge SYS_CLK);
    chk({RESULT_VALID, SEL_RAM, SEL_IO, SEL_SIO, MEM_STROBE}, 5'h00);
    SRST = 1'b0;
    t_ram();
    t_io();
    t_sio();
    t_hold();
    tally_and_finish();
  end
  // about 100 cycles expected, generous margin
  initial begin
    #(1500 * 40);
    err_total++;
    tally_and_finish();
  end
endmodule // asm_mapper_bench
